// ===== rtl/mbelm_pkg.sv
// Package: offsets, field layouts, reset values and state types of the memory error log block
package mbelm_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_FIRST_LOG = 8'ha0;
  localparam logic [7:0] OFF_NEXT_LOG = 8'ha4;
  localparam logic [7:0] OFF_MASK = 8'ha8;
  localparam logic [7:0] OFF_IRQ_STS = 8'hb0;
  localparam logic [7:0] OFF_IRQ_MSK = 8'hb4;

  // ------------------------------------------------------------------
  // Field layouts
  // ------------------------------------------------------------------
  // Log bits that an error source can set
  localparam logic [31:0] LOG_SRC_BITS = 32'h0187efff;
  // Log bits that exist as storage (sources plus future-use bits 22:19)
  localparam logic [31:0] LOG_IMPL_BITS = 32'h01ffefff;
  // Mask bits that exist as storage
  localparam logic [31:0] MASK_IMPL_BITS = 32'h0fff7fff;
  localparam logic [31:0] MASK_RESET = 32'h0fff7fff;
  // Mask bit n maps onto log bit n - LOG_SHIFT for non-fatal sources
  localparam int LOG_SHIFT = 3;
  localparam int SRC_W = 28;
  localparam int FATAL_W = 3;
  localparam logic [31:0] FUTURE_BITS = 32'h00780000;
  localparam logic [31:0] RSV_MASK_BITS = 32'hf0008000;
  localparam int BIT_SPARE_DONE = 24;
  localparam int BIT_SPARE_BEGUN = 23;
  localparam int BIT_PD_PROTOCOL = 18;
  localparam int BIT_SYNC_CRC = 17;
  localparam int BIT_PATROL_CORR = 16;
  localparam int BIT_READ_CRC = 11;
  localparam int BIT_PATROL_UNCORR = 8;
  localparam int BIT_REPLAY_UNCORR = 0;

  // Interrupt status layout
  localparam int IRQ_W = 3;
  localparam int IRQ_NF_LOGGED = 0;
  localparam int IRQ_FATAL = 1;
  localparam int IRQ_SPARE_DONE = 2;
  localparam logic [IRQ_W-1:0] IRQ_MSK_RESET = 3'h0;

  typedef logic [SRC_W-1:0] mbelm_src_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] first_log;
    logic [31:0] next_log;
    logic [31:0] err_mask;
    logic [IRQ_W-1:0] irq_sts;
    logic [IRQ_W-1:0] irq_msk;
    logic irq;
    logic fatal;
  } mbelm_state_t;

endpackage

// ===== rtl/mbelm_prio.sv
// Highest-order set bit picker for the one-flag first log
`timescale 1ns/10ps
module mbelm_prio #(
  parameter int W = 32
) (
  input wire logic [W-1:0] req,
  output logic [W-1:0] win
);

  always_comb begin
    win = '0;
    for (int i = 0; i < W; i++) begin
      if (req[i]) begin
        win = '0;
        win[i] = 1'b1;
      end
    end
  end

endmodule

// ===== rtl/mbelm_top.sv
// Memory error log and enable mask with APB register access
// ------------------------------------------------------------------
// Summary of operation
// - Later errors go to next log when first full
// - First log holds one flag, higher bit wins
// - Next bit 24 copy done, 23 copy begun
// - Next bit 18 presence protocol, 17 sync CRC
// - Correctable ECC flags at next bits 16..13
// - Read CRC 11, config alert 10, memory alert 9
// - Non-aliased uncorrectable ECC at bits 8..5
// - Aliased uncorrectable 4..1, replay at 0
// - Bits 22..19 storage only, reset zero
// - Mask zero enables, one disables the source
// - Mask 27,26,21,20 placed, reset to one
// - Mask 19..16, 14..3 reset one, 15 reserved
// - Mask 2 thermal, 1 retry CRC, reset one
// - Mask 0 retry alert; 31..28 read zero
// ------------------------------------------------------------------
//
// Decided for this implementation: the APB register port.
`timescale 1ns/10ps
module mbelm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mbelm_pkg::mbelm_src_t err_src,
  output logic fatal_event,
  output logic irq
);

  mbelm_pkg::mbelm_state_t s_q;
  mbelm_pkg::mbelm_state_t s_d;

  logic [31:0] byte_en;
  logic setup_ph;
  logic wr_acc;
  logic sel_first;
  logic sel_next;
  logic sel_mask;
  logic sel_ists;
  logic sel_imsk;
  logic mapped;
  logic [31:0] wr_one;
  logic [mbelm_pkg::SRC_W-1:0] src_en;
  logic [31:0] nf_new;
  logic [31:0] nf_win;
  logic [31:0] first_clr;
  logic first_busy;
  logic fatal_new;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  assign setup_ph = psel && !penable;
  assign wr_acc = ce && psel && penable && pwrite && s_q.pready;
  assign sel_first = (paddr == mbelm_pkg::OFF_FIRST_LOG);
  assign sel_next = (paddr == mbelm_pkg::OFF_NEXT_LOG);
  assign sel_mask = (paddr == mbelm_pkg::OFF_MASK);
  assign sel_ists = (paddr == mbelm_pkg::OFF_IRQ_STS);
  assign sel_imsk = (paddr == mbelm_pkg::OFF_IRQ_MSK);
  assign mapped = sel_first || sel_next || sel_mask || sel_ists || sel_imsk;
  assign byte_en = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
  assign wr_one = pwdata & byte_en;

  // ------------------------------------------------------------------
  // Error intake
  // ------------------------------------------------------------------
  assign src_en = err_src & ~s_q.err_mask[mbelm_pkg::SRC_W-1:0];
  // Mask bit n feeds log bit n-3; fatal sources drop off the bottom
  assign nf_new = 32'(src_en >> mbelm_pkg::LOG_SHIFT) & mbelm_pkg::LOG_SRC_BITS;
  assign fatal_new = |src_en[mbelm_pkg::FATAL_W-1:0];
  // A clear in the same cycle frees the first log for the new event
  assign first_clr = (wr_acc && sel_first) ? (s_q.first_log & ~wr_one) : s_q.first_log;
  assign first_busy = |first_clr;

  mbelm_prio #(
    .W(32)
  ) i_mbelm_prio (
    .req(nf_new),
    .win(nf_win)
  );

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.pready = 1'b0;
    s_d.pslverr = 1'b0;
    if (setup_ph) begin
      s_d.pready = 1'b1;
      s_d.pslverr = !mapped;
      s_d.prdata = 32'h0;
      if (!pwrite) begin
        if (sel_first) begin
          s_d.prdata = s_q.first_log;
        end else if (sel_next) begin
          s_d.prdata = s_q.next_log;
        end else if (sel_mask) begin
          s_d.prdata = s_q.err_mask;
        end else if (sel_ists) begin
          s_d.prdata = 32'(s_q.irq_sts);
        end else if (sel_imsk) begin
          s_d.prdata = 32'(s_q.irq_msk);
        end
      end
    end

    // Write-one-clear first, hardware set afterwards so a set wins
    s_d.first_log = first_clr;
    if (wr_acc && sel_next) begin
      s_d.next_log = s_q.next_log & ~wr_one;
    end
    if (wr_acc && sel_mask) begin
      s_d.err_mask = ((s_q.err_mask & ~byte_en) | wr_one) & mbelm_pkg::MASK_IMPL_BITS;
    end
    if (wr_acc && sel_ists) begin
      s_d.irq_sts = s_q.irq_sts & ~wr_one[mbelm_pkg::IRQ_W-1:0];
    end
    if (wr_acc && sel_imsk) begin
      s_d.irq_msk = wr_one[mbelm_pkg::IRQ_W-1:0];
    end

    if (!first_busy) begin
      s_d.first_log = nf_win;
      s_d.next_log = s_d.next_log | (nf_new & ~nf_win);
    end else begin
      s_d.next_log = s_d.next_log | nf_new;
    end

    if (|nf_new) begin
      s_d.irq_sts[mbelm_pkg::IRQ_NF_LOGGED] = 1'b1;
    end
    if (fatal_new) begin
      s_d.irq_sts[mbelm_pkg::IRQ_FATAL] = 1'b1;
    end
    if (nf_new[mbelm_pkg::BIT_SPARE_DONE]) begin
      s_d.irq_sts[mbelm_pkg::IRQ_SPARE_DONE] = 1'b1;
    end
    s_d.fatal = fatal_new;
    s_d.irq = |(s_d.irq_sts & ~s_d.irq_msk);
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  // Only the power-on reset touches the sticky logs and mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{prdata: 32'h0, pready: 1'b0, pslverr: 1'b0, first_log: 32'h0, next_log: 32'h0,
               err_mask: mbelm_pkg::MASK_RESET, irq_sts: '0, irq_msk: mbelm_pkg::IRQ_MSK_RESET,
               irq: 1'b0, fatal: 1'b0};
    end else if (ce) begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign fatal_event = s_q.fatal;
  assign irq = s_q.irq;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // First log intake and priority
  AST_NEXT_WHEN_FULL: assert property ((ce && first_busy && nf_new[5]) |=> s_q.next_log[5])
    else $error("event lost while first log full");
  AST_FIRST_HOLD: assert property ((ce && first_busy) |=> (s_q.first_log == $past(s_q.first_log)))
    else $error("busy first log overwritten");
  AST_FIRST_TAKES: assert property ((ce && !first_busy && nf_new != 32'h0) |=> (s_q.first_log != 32'h0))
    else $error("event not taken by empty first log");
  AST_FIRST_ONE_FLAG: assert property ($onehot0(s_q.first_log))
    else $error("first log holds more than one flag");
  // Bit 16 is the highest new bit here, so it alone may win
  AST_FIRST_PRIO: assert property ((ce && !first_busy && nf_new[31:16] == 16'h0001 && nf_new[3]) |=>
      (s_q.first_log[16] && !s_q.first_log[3] && s_q.next_log[3]))
    else $error("higher bit lost priority");

  // ------------------------------------------------------------------
  // Source placement, one position at a time with the first log busy
  // ------------------------------------------------------------------
  AST_SPARE_DONE: assert property ((ce && first_busy && err_src[27] && !s_q.err_mask[27]) |=>
      s_q.next_log[mbelm_pkg::BIT_SPARE_DONE])
    else $error("spare copy done not logged at bit 24");
  AST_SPARE_BEGUN: assert property ((ce && first_busy && err_src[26] && !s_q.err_mask[26]) |=>
      s_q.next_log[mbelm_pkg::BIT_SPARE_BEGUN])
    else $error("spare copy begun not logged at bit 23");
  AST_PD_PROTOCOL: assert property ((ce && first_busy && err_src[21] && !s_q.err_mask[21]) |=>
      s_q.next_log[mbelm_pkg::BIT_PD_PROTOCOL])
    else $error("presence protocol error not at bit 18");
  AST_SYNC_CRC: assert property ((ce && first_busy && err_src[20] && !s_q.err_mask[20]) |=>
      s_q.next_log[mbelm_pkg::BIT_SYNC_CRC])
    else $error("sync status CRC not at bit 17");
  AST_PATROL_CORR: assert property ((ce && first_busy && err_src[19] && !s_q.err_mask[19]) |=>
      s_q.next_log[mbelm_pkg::BIT_PATROL_CORR])
    else $error("patrol correctable not at bit 16");
  AST_SPARE_CORR: assert property ((ce && first_busy && err_src[18] && !s_q.err_mask[18]) |=>
      s_q.next_log[15])
    else $error("spare copy correctable not at bit 15");
  AST_MIRROR_CORR: assert property ((ce && first_busy && err_src[17] && !s_q.err_mask[17]) |=>
      s_q.next_log[14])
    else $error("mirrored correctable not at bit 14");
  AST_PLAIN_CORR: assert property ((ce && first_busy && err_src[16] && !s_q.err_mask[16]) |=>
      s_q.next_log[13])
    else $error("non-mirrored correctable not at bit 13");
  AST_READ_CRC: assert property ((ce && first_busy && err_src[14] && !s_q.err_mask[14]) |=>
      s_q.next_log[mbelm_pkg::BIT_READ_CRC])
    else $error("read CRC not at bit 11");
  AST_CFG_ALERT: assert property ((ce && first_busy && err_src[13] && !s_q.err_mask[13]) |=>
      s_q.next_log[10])
    else $error("configuration alert not at bit 10");
  AST_MEM_ALERT: assert property ((ce && first_busy && err_src[12] && !s_q.err_mask[12]) |=>
      s_q.next_log[9])
    else $error("memory alert not at bit 9");
  AST_PATROL_UNCORR: assert property ((ce && first_busy && err_src[11] && !s_q.err_mask[11]) |=>
      s_q.next_log[mbelm_pkg::BIT_PATROL_UNCORR])
    else $error("patrol uncorrectable not at bit 8");
  AST_SPARE_UNCORR: assert property ((ce && first_busy && err_src[10] && !s_q.err_mask[10]) |=>
      s_q.next_log[7])
    else $error("spare copy uncorrectable not at bit 7");
  AST_MIRROR_UNCORR: assert property ((ce && first_busy && err_src[9] && !s_q.err_mask[9]) |=>
      s_q.next_log[6])
    else $error("mirrored uncorrectable not at bit 6");
  AST_PLAIN_UNCORR: assert property ((ce && first_busy && err_src[8] && !s_q.err_mask[8]) |=>
      s_q.next_log[5])
    else $error("non-mirrored uncorrectable not at bit 5");
  AST_ALIAS_PATROL: assert property ((ce && first_busy && err_src[7] && !s_q.err_mask[7]) |=>
      s_q.next_log[4])
    else $error("aliased patrol uncorrectable not at bit 4");
  AST_ALIAS_SPARE: assert property ((ce && first_busy && err_src[6] && !s_q.err_mask[6]) |=>
      s_q.next_log[3])
    else $error("aliased spare uncorrectable not at bit 3");
  AST_ALIAS_MIRROR: assert property ((ce && first_busy && err_src[5] && !s_q.err_mask[5]) |=>
      s_q.next_log[2])
    else $error("aliased mirrored uncorrectable not at bit 2");
  AST_ALIAS_PLAIN: assert property ((ce && first_busy && err_src[4] && !s_q.err_mask[4]) |=>
      s_q.next_log[1])
    else $error("aliased non-mirrored uncorrectable not at bit 1");
  AST_REPLAY: assert property ((ce && first_busy && err_src[3] && !s_q.err_mask[3]) |=>
      s_q.next_log[mbelm_pkg::BIT_REPLAY_UNCORR])
    else $error("replay uncorrectable not at bit 0");

  // ------------------------------------------------------------------
  // Storage, masking and signalling
  // ------------------------------------------------------------------
  // Future-use bits exist only so software sees stable zeros
  AST_FUTURE_ZERO: assert property (((s_q.next_log | s_q.first_log) & mbelm_pkg::FUTURE_BITS) == 32'h0)
    else $error("future-use log bit set by hardware");
  AST_MASK_RSV: assert property ((s_q.err_mask & mbelm_pkg::RSV_MASK_BITS) == 32'h0)
    else $error("reserved mask bit set");
  AST_MASK_BLOCKS: assert property ((ce && (err_src & s_q.err_mask[mbelm_pkg::SRC_W-1:0]) == err_src) |=>
      ((s_q.next_log & ~$past(s_q.next_log)) == 32'h0 && !fatal_event))
    else $error("masked source raised a flag");
  AST_MASKED_SILENT: assert property ((ce && (err_src & ~s_q.err_mask[mbelm_pkg::SRC_W-1:0]) == '0 &&
      !(wr_acc && sel_ists)) |=> (s_q.irq_sts == $past(s_q.irq_sts)))
    else $error("masked source changed interrupt status");
  AST_FATAL_MASKED: assert property ((ce && (err_src[2:0] & ~s_q.err_mask[2:0]) == 3'h0) |=> !fatal_event)
    else $error("masked fatal source signalled");
  AST_ENABLED_SIGNALS: assert property ((ce && nf_new != 32'h0) |=> s_q.irq_sts[mbelm_pkg::IRQ_NF_LOGGED])
    else $error("enabled source not signalled");
  AST_FATAL_PULSE: assert property ((ce && err_src[1] && !s_q.err_mask[1]) |=> fatal_event)
    else $error("enabled fatal source not signalled");
  AST_THERMAL: assert property ((ce && err_src[2] && !s_q.err_mask[2]) |=> fatal_event)
    else $error("enabled thermal source not signalled");
  AST_RETRY_ALERT: assert property ((ce && err_src[0] && !s_q.err_mask[0]) |=> fatal_event)
    else $error("enabled retry alert not signalled");
  // Fatal sources pulse and set the fatal status flag; they must never reach the next log
  AST_FATAL_NOT_LOGGED: assert property ((ce && err_src[27:3] == 25'h0 && !wr_acc) |=>
      (s_q.next_log == $past(s_q.next_log)))
    else $error("fatal source reached the log");
  AST_SPARE_IRQ: assert property ((ce && err_src[27] && !s_q.err_mask[27]) |=>
      s_q.irq_sts[mbelm_pkg::IRQ_SPARE_DONE])
    else $error("spare copy done not signalled");

  // ------------------------------------------------------------------
  // Software access
  // ------------------------------------------------------------------
  // Only the strobed lanes of a write may clear or change anything, but the interrupt mask takes zeros from an unstrobed lane 0
  AST_W1C_NEXT: assert property ((wr_acc && sel_next && nf_new == 32'h0 && pstrb == 4'hf) |=>
      ((s_q.next_log & $past(pwdata)) == 32'h0))
    else $error("write one did not clear next log");
  AST_W1C_FIRST: assert property ((wr_acc && sel_first && nf_new == 32'h0 && pstrb == 4'hf) |=>
      ((s_q.first_log & $past(pwdata)) == 32'h0))
    else $error("write one did not clear first log");
  AST_MASK_WRITE: assert property ((wr_acc && sel_mask && pstrb == 4'hf) |=>
      (s_q.err_mask == ($past(pwdata) & mbelm_pkg::MASK_IMPL_BITS)))
    else $error("mask write not stored");
  AST_MASK_STICKY: assert property ((ce && !(wr_acc && sel_mask)) |=>
      (s_q.err_mask == $past(s_q.err_mask)))
    else $error("mask changed without a write");
  // Without a write no flag may drop, whatever else happens
  AST_LOG_STICKY: assert property ((ce && !wr_acc) |=>
      ((s_q.next_log & $past(s_q.next_log)) == $past(s_q.next_log)))
    else $error("next log flag lost without a write");

endmodule

// ===== tb/test_mbelm_top.sv
// Self-checking bench for the memory error log and enable mask block
`timescale 1ns/10ps
module test_mbelm_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fatal_event;
  logic irq;
  logic ce = 1'b1;
  mbelm_pkg::mbelm_src_t err_src = '0;
  logic [32:0] rq[$];
  int fq = 0;
  int n_mismatch = 0;
  int n_checks = 0;
  logic [31:0] acc;
  int k;

  always #5 pclk = ~pclk;

  mbelm_top i_mbelm_top (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .err_src(err_src), .fatal_event(fatal_event), .irq(irq));

  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test;
    $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [32:0] exp);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    if (!wr) rq.push_back(exp);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_mismatch++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hf, 33'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    apb(1'b0, a, 32'h0, 4'h0, exp);
  endtask

  task automatic pulse(input mbelm_pkg::mbelm_src_t s);
    @(posedge pclk);
    err_src <= s;
    @(posedge pclk);
    err_src <= '0;
  endtask

  task automatic irq_is(input logic exp);
    repeat (2) @(posedge pclk);
    check({32'h0, irq}, {32'h0, exp});
  endtask

  // ------------------------------------------------------------------
  // Output watcher
  // ------------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      if (rq.size() == 0) check(33'h1, 33'h0);
      else check({pslverr, prdata}, rq.pop_front());
    end
    if (fatal_event === 1'b1) begin
      check({32'h0, fq > 0}, 33'h1);
      fq--;
    end
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    void'($urandom(32'h26a3));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'ha4, 33'h0);
    rd(8'ha8, {1'b0, 32'h0fff7fff});
    rd(8'hbc, {1'b1, 32'h0});
    wr(8'ha8, 32'hffffffff);
    rd(8'ha8, {1'b0, 32'h0fff7fff});
    wr(8'ha8, 32'h0);
    rd(8'ha8, 33'h0);
    $display("reset and mask storage done");
    // Two at once into an empty first log: higher bit wins
    pulse(28'h8000008);
    rd(8'ha0, {1'b0, 32'h01000000});
    rd(8'ha4, {1'b0, 32'h00000001});
    // Reserved and sourceless positions must leave the log alone
    acc = 32'h1;
    for (k = 3; k < 28; k++) begin
      pulse(mbelm_pkg::mbelm_src_t'(1) << k);
      if (k != 15 && !(k inside {[22:25]})) acc[k-3] = 1'b1;
      rd(8'ha4, {1'b0, acc});
    end
    $display("source placement done");
    apb(1'b1, 8'ha4, 32'hffffffff, 4'h1, 33'h0);
    acc[7:0] = 8'h00;
    rd(8'ha4, {1'b0, acc});
    wr(8'ha4, 32'hffffffff);
    rd(8'ha4, 33'h0);
    wr(8'ha0, 32'hffffffff);
    rd(8'ha0, 33'h0);
    // Two at once into an empty first log: bit 16 beats bit 3
    pulse(28'h0080040);
    rd(8'ha0, {1'b0, 32'h00010000});
    rd(8'ha4, {1'b0, 32'h00000008});
    rd(8'hb0, {1'b0, 32'h00000005});
    wr(8'ha4, 32'hffffffff);
    wr(8'ha0, 32'hffffffff);
    irq_is(1'b1);
    wr(8'hb0, 32'h7);
    irq_is(1'b0);
    $display("clear and interrupt done");
    // Fatal sources signal but never log
    wr(8'hb4, 32'h7);
    rd(8'hb4, {1'b0, 32'h7});
    fq++;
    pulse(28'h7);
    rd(8'ha4, 33'h0);
    rd(8'hb0, {1'b0, 32'h2});
    irq_is(1'b0);
    wr(8'hb4, 32'h0);
    irq_is(1'b1);
    wr(8'hb0, 32'h2);
    irq_is(1'b0);
    $display("fatal and interrupt mask done");
    // Everything disabled: random bursts leave no trace
    wr(8'ha8, 32'h0fffffff);
    for (k = 0; k < 20; k++) begin
      pulse(mbelm_pkg::mbelm_src_t'($urandom));
    end
    rd(8'ha4, 33'h0);
    rd(8'ha0, 33'h0);
    rd(8'hb0, 33'h0);
    // Only one source enabled
    wr(8'ha8, 32'h0fffdfff);
    pulse(mbelm_pkg::mbelm_src_t'($urandom) | 28'h2000);
    rd(8'ha0, {1'b0, 32'h00000400});
    rd(8'ha4, 33'h0);
    // Clock enable low: an enabled event must not be taken
    @(posedge pclk);
    ce <= 1'b0;
    pulse(28'h2000);
    @(posedge pclk);
    ce <= 1'b1;
    rd(8'ha4, 33'h0);
    rd(8'ha0, {1'b0, 32'h00000400});
    $display("masking done");
    repeat (3) @(posedge pclk);
    check({1'b0, 32'(fq)}, 33'h0);
    end_of_test();
  end
endmodule
